//--- mviu_checker.sv
// Port checker for the vectored interrupt unit.
// Assumes it is bound onto mviu_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module mviu_checker
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pslverr,
  input wire mviu_pkg::mviu_core_t core_in,
  input wire mviu_pkg::mviu_req_t  irq_req,
  input wire logic                 wake_up
);
  logic acc;
  logic map;
  // Access phase and a decode of the three mapped indices.
  assign acc = psel && penable;
  assign map = paddr[9:2] == mviu_pkg::IDX_IRQ_CTRL_FIRST
            || paddr[9:2] == mviu_pkg::IDX_IRQ_CTRL_SECOND
            || paddr[9:2] == mviu_pkg::IDX_IRQ_CONFIG;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ack_drops_req: assert property (
    irq_req.valid && core_in.irq_ack |=> !irq_req.valid [*2])
    else $error("request stayed after acknowledge");
  a_full_blocks: assert property (
    core_in.stack_full && core_in.phase_two_pulse |=> !irq_req.valid)
    else $error("request raised while stack full");
  a_vector_table: assert property (
    irq_req.valid |-> irq_req.vector == 12'h004 + {7'h0, irq_req.source, 2'h0})
    else $error("vector does not match source");
  a_rise_on_strobe: assert property (
    $rose(irq_req.valid) |-> $past(core_in.phase_two_pulse))
    else $error("request rose without a phase strobe");
  a_unmapped_err: assert property (acc |-> pslverr == !map)
    else $error("error response wrong for index");
  a_unused_zero: assert property (
    acc && !pwrite && map |-> !prdata[7]
    && (paddr[9:2] != mviu_pkg::IDX_IRQ_CTRL_SECOND || !prdata[3]))
    else $error("unused bit read as one");
  a_wake_source: assert property ($rose(irq_req.valid) |-> wake_up)
    else $error("request without wake");
  // A write one cycle earlier may have cleared the global enable, which drops the request.
  a_req_stands: assert property (
    irq_req.valid && core_in == '0 && !(acc && pwrite) && !$past(acc && pwrite)
    |=> $stable(irq_req))
    else $error("request changed without cause");
  c_ack: cover property (irq_req.valid && core_in.irq_ack);
  c_full: cover property (core_in.stack_full && core_in.phase_two_pulse);
  c_err: cover property (acc && pslverr);
endmodule
bind mviu_top mviu_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pslverr, .core_in, .irq_req, .wake_up);
`default_nettype wire

//--- mviu_core_model.sv
// Core-side model: phase strobe, acknowledge, return stack and returns.
// Assumes the unit's request port and a bench that commands the returns.
`timescale 1ns/1ps
`default_nettype none
module mviu_core_model
#(
  parameter int DEPTH = 6
)
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire mviu_pkg::mviu_req_t  irq_req,
  input  wire logic [3:0]           ack_dly,
  input  wire logic                 ret_go,
  input  wire logic                 ret_en,
  output mviu_pkg::mviu_core_t      core_in,
  output logic [11:0]               last_vec,
  output logic [3:0]                depth
);
  logic [1:0] ph_r;
  logic [3:0] wait_r;
  logic       pt_r, ack_r, return_from_irq_r, ret_r;
  // Stack full is a level taken from the live depth.
  assign core_in = '{pt_r, ack_r, return_from_irq_r, ret_r, depth == DEPTH};
  // Strobe every fourth cycle, acknowledge after a wait, push and pop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_r     <= 2'h0;
      wait_r   <= 4'h0;
      {pt_r, ack_r, return_from_irq_r, ret_r} <= 4'h0;
      depth    <= 4'h0;
      last_vec <= 12'h000;
    end
    else
    begin
      ph_r   <= ph_r + 2'h1;
      pt_r   <= ph_r == 2'h3;
      wait_r <= irq_req.valid ? wait_r + 4'h1 : 4'h0;
      ack_r  <= 1'b0;
      return_from_irq_r <= ret_go && ret_en;
      ret_r  <= ret_go && !ret_en;
      // Only the program counter is pushed; status is never saved.
      if (irq_req.valid && !ack_r && wait_r >= ack_dly)
      begin
        ack_r    <= 1'b1;
        depth    <= depth + 4'h1;
        last_vec <= irq_req.vector;
      end
      else if (ret_go && depth != 4'h0)
        depth <= depth - 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- mviu_pkg.sv
// Package for the vectored interrupt unit: register map, field positions,
// reset values, vectors and the core-facing carrier types.
// Assumes an APB slave with 32-bit data and byte addresses four times the index.
// Behaviour
// - Acknowledge clears global enable and the serviced flag.
// - No acknowledge while return stack full.
// - Any pending enabled source wakes power-down.
// - Acknowledge pushes only PC, branches vector.
// - External pin edge, chosen polarity, sets flag.
// - External calls 04H/08H, clear flag, global.
// - Timer 0 overflow flag, vector 0CH.
// - Timer 1 overflow flag, vector 14H.
// - RC converter overflow flag, vector 10H.
// - A/D end flag, vector 18H.
// - Return with reenable sets global enable.
// - Further acknowledges held until reenabled, stack permitting.
// - Requests sampled, serviced on next phase pulse.
// - Fixed priority ext0, ext1, tmr0, rc, tmr1, adc.
// - Global enable clear masks every source.
// - First register enable bits 0-3, bit7 zero.
// - Second register enables bits 0-2, 3,7 zero.
// - Pending flag reads one while active.
// - Software set flag raises interrupt.
// - Status register never saved automatically.
// - Pending stays set until serviced or cleared.
`default_nettype none
package mviu_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] IDX_IRQ_CTRL_FIRST  = 8'h0B;
  localparam logic [7:0] IDX_IRQ_CTRL_SECOND = 8'h1E;
  localparam logic [7:0] IDX_IRQ_CONFIG      = 8'h30;

  // First control register fields.
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_EXT0_EN   = 1;
  localparam int BIT_EXT1_EN   = 2;
  localparam int BIT_TMR0_EN   = 3;
  localparam int BIT_EXT0_PEND = 4;
  localparam int BIT_EXT1_PEND = 5;
  localparam int BIT_TMR0_PEND = 6;

  // Second control register fields.
  localparam int BIT_RCC_EN    = 0;
  localparam int BIT_TMR1_EN   = 1;
  localparam int BIT_ADC_EN    = 2;
  localparam int BIT_RCC_PEND  = 4;
  localparam int BIT_TMR1_PEND = 5;
  localparam int BIT_ADC_PEND  = 6;

  // Configuration register fields: edge polarity, one means rising.
  localparam int BIT_EXT0_RISE = 0;
  localparam int BIT_EXT1_RISE = 1;

  // Reset values.
  localparam logic [7:0] RST_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] RST_CTRL_SECOND = 8'h00;
  localparam logic [1:0] RST_CONFIG      = 2'h0;

  // Source numbering in priority order, highest first.
  localparam int NUM_SRC  = 6;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_TMR0 = 2;
  localparam int SRC_RCC  = 3;
  localparam int SRC_TMR1 = 4;
  localparam int SRC_ADC  = 5;

  // Vectors in program memory.
  localparam logic [11:0] VEC_EXT0 = 12'h004;
  localparam logic [11:0] VEC_EXT1 = 12'h008;
  localparam logic [11:0] VEC_TMR0 = 12'h00C;
  localparam logic [11:0] VEC_RCC  = 12'h010;
  localparam logic [11:0] VEC_TMR1 = 12'h014;
  localparam logic [11:0] VEC_ADC  = 12'h018;

  // Request presented to the core.
  typedef struct packed {
    logic        valid;
    logic [2:0]  source;
    logic [11:0] vector;
  } mviu_req_t;

  // Sequencer events from the core.
  typedef struct packed {
    logic phase_two_pulse;
    logic irq_ack;
    logic return_from_irq;
    logic return_plain;
    logic stack_full;
  } mviu_core_t;

endpackage
`default_nettype wire

//--- mviu_tb_top.sv
// Self-checking bench for the vectored interrupt unit.
// Assumes the core model with a one-entry stack and APB at 250 MHz.
`timescale 1ns/1ps
`default_nettype none
module mviu_tb_top;
  localparam logic [7:0] F = mviu_pkg::IDX_IRQ_CTRL_FIRST;
  localparam logic [7:0] S = mviu_pkg::IDX_IRQ_CTRL_SECOND;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, wake_up;
  logic        ret_go, ret_en, ext_irq_pin_zero, ext_irq_pin_one;
  logic        tmr0_overflow, tmr1_overflow, rcconv_overflow, adc_done;
  logic [11:0] paddr, last_vec;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb, ack_dly, depth;
  logic [7:0]  rv;
  mviu_pkg::mviu_core_t core_in;
  mviu_pkg::mviu_req_t  irq_req;
  int          seed, n_fail, total_checks, k, r;
  mviu_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .ext_irq_pin_zero, .ext_irq_pin_one, .tmr0_overflow,
    .tmr1_overflow, .rcconv_overflow, .adc_done, .core_in, .irq_req, .wake_up);
  mviu_core_model #(.DEPTH(1)) u_core (.pclk, .presetn, .irq_req, .ack_dly, .ret_go,
    .ret_en, .core_in, .last_vec, .depth);
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(q, {24'h0, exp});
  endtask
  task automatic wdep(input logic [3:0] v);
    for (int i = 0; i < 300 && depth !== v; i++) @(posedge pclk);
    chk({28'h0, depth}, {28'h0, v});
  endtask
  task automatic ret(input logic en);
    @(posedge pclk);
    ret_go <= 1'b1;
    ret_en <= en;
    @(posedge pclk);
    ret_go <= 1'b0;
    @(posedge pclk);
  endtask
  // Expected registers once sources up to k are serviced.
  function automatic logic [7:0] ef(input int k, input logic g);
    logic [5:0] m;
    m = 6'h3F << (k + 1);
    return {1'b0, m[2:0], 3'h7, g};
  endfunction
  function automatic logic [7:0] es(input int k);
    logic [5:0] m;
    m = 6'h3F << (k + 1);
    return {1'b0, m[5:3], 4'h7};
  endfunction
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    final_report;
  end
  // Main sequence: registers, six sources twice, full stack, software request.
  initial
  begin
    {presetn, psel, penable, pwrite, ret_go, ret_en} = 6'h00;
    {tmr0_overflow, tmr1_overflow, rcconv_overflow, adc_done} = 4'h0;
    {ext_irq_pin_zero, ext_irq_pin_one} = 2'h3;
    {paddr, pwdata, pstrb, ack_dly} = {12'h000, 32'h0, 4'hF, 4'h0};
    {seed, n_fail, total_checks} = {32'h7361E6EB, 64'h0};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rc(F, mviu_pkg::RST_CTRL_FIRST);
    rc(S, mviu_pkg::RST_CTRL_SECOND);
    rc(8'h05, 8'h00);
    chk(e, 1'b1);
    apb(1'b1, F, 8'hFE);
    rc(F, 8'h7E);
    chk(wake_up, 1'b1);
    apb(1'b1, S, 8'hFF);
    rc(S, 8'h77);
    // Random enables and flags in the second register while the global enable is off.
    for (k = 0; k < 4; k++)
    begin
      rv = 8'($random(seed));
      apb(1'b1, S, rv);
      rc(S, rv & 8'h77);
    end
    for (r = 0; r < 2; r++)
    begin
      apb(1'b1, mviu_pkg::IDX_IRQ_CONFIG, {6'h0, r[0], r[0]});
      apb(1'b1, F, 8'h0E);
      apb(1'b1, S, 8'h07);
      ext_irq_pin_zero <= r[0];
      ext_irq_pin_one  <= r[0];
      {tmr0_overflow, tmr1_overflow, rcconv_overflow, adc_done} <= 4'hF;
      @(posedge pclk);
      {tmr0_overflow, tmr1_overflow, rcconv_overflow, adc_done} <= 4'h0;
      rc(F, ef(-1, 1'b0));
      rc(S, es(-1));
      apb(1'b1, F, 8'h7F);
      for (k = 0; k < 6; k++)
      begin
        ack_dly <= 4'($random(seed) & 7);
        wdep(4'h1);
        chk(last_vec, 12'(4 * (k + 1)));
        rc(F, ef(k, 1'b0));
        rc(S, es(k));
        if (k < 5)
        begin
          apb(1'b1, F, ef(k, 1'b1));
          repeat (12) @(posedge pclk);
          chk(last_vec, 12'(4 * (k + 1)));
          ret(1'($random(seed)));
        end
        else
        begin
          ret(r == 0);
          rc(F, ef(5, r == 0));
        end
      end
    end
    apb(1'b1, S, 8'h17);
    repeat (12) @(posedge pclk);
    chk({28'h0, depth}, 32'h0);
    apb(1'b1, F, 8'h0F);
    wdep(4'h1);
    chk(last_vec, mviu_pkg::VEC_RCC);
    ret(1'b1);
    final_report;
  end
endmodule
`default_nettype wire

//--- mviu_top.sv
// Vectored interrupt unit: two control registers, edge detect, priority,
// request sampling on the phase-two strobe and acknowledge handling.
// Assumes the core pushes the program counter and branches on irq_ack.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mviu_top
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic                 ext_irq_pin_zero,
  input  wire logic                 ext_irq_pin_one,
  input  wire logic                 tmr0_overflow,
  input  wire logic                 tmr1_overflow,
  input  wire logic                 rcconv_overflow,
  input  wire logic                 adc_done,
  input  wire mviu_pkg::mviu_core_t core_in,
  output mviu_pkg::mviu_req_t       irq_req,
  output logic                      wake_up
);

  // Register state.
  logic [3:0] first_en_r;
  logic [2:0] second_en_r;
  logic [5:0] pending_r;
  logic [5:0] pending_nxt;
  logic [1:0] config_r;
  logic       pin0_d_r;
  logic       pin1_d_r;
  logic       hist_ok_r;
  mviu_pkg::mviu_req_t req_r;

  // APB decode.
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  idx;
  logic        hit_first;
  logic        hit_second;
  logic        hit_config;
  logic        edge0;
  logic        edge1;
  logic [5:0]  hw_set;
  logic [5:0]  enabled;
  logic [5:0]  ack_clr;

  // Picks the highest-priority set bit of a six-bit vector.
  function automatic logic [2:0] pick_src(input logic [5:0] v);
    logic [2:0] s;
    s = 3'h0;
    for (int i = mviu_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        s = 3'(i);
      end
    end
    return s;
  endfunction

  // Maps a source number to its program memory vector.
  function automatic logic [11:0] src_vec(input logic [2:0] s);
    logic [11:0] v;
    case (s)
      3'h0:    v = mviu_pkg::VEC_EXT0;
      3'h1:    v = mviu_pkg::VEC_EXT1;
      3'h2:    v = mviu_pkg::VEC_TMR0;
      3'h3:    v = mviu_pkg::VEC_RCC;
      3'h4:    v = mviu_pkg::VEC_TMR1;
      default: v = mviu_pkg::VEC_ADC;
    endcase
    return v;
  endfunction

  // Zero-wait APB slave; any index outside the map answers with an error.
  assign idx        = paddr[9:2];
  assign hit_first  = (idx == mviu_pkg::IDX_IRQ_CTRL_FIRST);
  assign hit_second = (idx == mviu_pkg::IDX_IRQ_CTRL_SECOND);
  assign hit_config = (idx == mviu_pkg::IDX_IRQ_CONFIG);
  assign wr_en      = psel && penable && pwrite && pstrb[0]
                      && (hit_first || hit_second || hit_config);
  assign rd_en      = psel && !penable && !pwrite; // Read data is taken in the setup cycle.
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !(hit_first || hit_second || hit_config);

  // Edge detection on the external pins with selectable polarity. The first cycle
  // after reset only fills the pin history, so a pin's resting level fakes no edge.
  assign edge0 = hist_ok_r && (config_r[mviu_pkg::BIT_EXT0_RISE] ?
                               (ext_irq_pin_zero && !pin0_d_r) :
                               (!ext_irq_pin_zero && pin0_d_r));
  assign edge1 = hist_ok_r && (config_r[mviu_pkg::BIT_EXT1_RISE] ?
                               (ext_irq_pin_one && !pin1_d_r) :
                               (!ext_irq_pin_one && pin1_d_r));

  // Hardware event vector in priority order.
  always_comb
  begin
    hw_set = 6'h00;
    hw_set[mviu_pkg::SRC_EXT0] = edge0;
    hw_set[mviu_pkg::SRC_EXT1] = edge1;
    hw_set[mviu_pkg::SRC_TMR0] = tmr0_overflow;
    hw_set[mviu_pkg::SRC_RCC]  = rcconv_overflow;
    hw_set[mviu_pkg::SRC_TMR1] = tmr1_overflow;
    hw_set[mviu_pkg::SRC_ADC]  = adc_done;
  end

  // Per-source enable, all gated by the global enable.
  always_comb
  begin
    enabled = 6'h00;
    enabled[mviu_pkg::SRC_EXT0] = first_en_r[mviu_pkg::BIT_EXT0_EN];
    enabled[mviu_pkg::SRC_EXT1] = first_en_r[mviu_pkg::BIT_EXT1_EN];
    enabled[mviu_pkg::SRC_TMR0] = first_en_r[mviu_pkg::BIT_TMR0_EN];
    enabled[mviu_pkg::SRC_RCC]  = second_en_r[mviu_pkg::BIT_RCC_EN];
    enabled[mviu_pkg::SRC_TMR1] = second_en_r[mviu_pkg::BIT_TMR1_EN];
    enabled[mviu_pkg::SRC_ADC]  = second_en_r[mviu_pkg::BIT_ADC_EN];
    enabled = enabled & {6{first_en_r[mviu_pkg::BIT_GLOBAL_EN]}};
  end

  // The acknowledged source loses its flag in the acknowledge cycle.
  always_comb
  begin
    ack_clr = 6'h00;
    if (core_in.irq_ack && req_r.valid)
    begin
      ack_clr[req_r.source] = 1'b1;
    end
  end

  // Pending flags: software write, then acknowledge clear, then hardware set wins.
  always_comb
  begin
    pending_nxt = pending_r;
    if (wr_en && hit_first)
    begin
      pending_nxt[mviu_pkg::SRC_EXT0] = pwdata[mviu_pkg::BIT_EXT0_PEND];
      pending_nxt[mviu_pkg::SRC_EXT1] = pwdata[mviu_pkg::BIT_EXT1_PEND];
      pending_nxt[mviu_pkg::SRC_TMR0] = pwdata[mviu_pkg::BIT_TMR0_PEND];
    end
    if (wr_en && hit_second)
    begin
      pending_nxt[mviu_pkg::SRC_RCC]  = pwdata[mviu_pkg::BIT_RCC_PEND];
      pending_nxt[mviu_pkg::SRC_TMR1] = pwdata[mviu_pkg::BIT_TMR1_PEND];
      pending_nxt[mviu_pkg::SRC_ADC]  = pwdata[mviu_pkg::BIT_ADC_PEND];
    end
    pending_nxt = (pending_nxt & ~ack_clr) | hw_set;
  end

  // Pending flag storage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_r <= 6'h00;
    end
    else
    begin
      pending_r <= pending_nxt;
    end
  end

  // Global enable: cleared on acknowledge, set by reenabling return.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_en_r <= mviu_pkg::RST_CTRL_FIRST[3:0];
    end
    else
    begin
      if (wr_en && hit_first)
      begin
        first_en_r <= pwdata[3:0];
      end
      if (core_in.irq_ack && req_r.valid)
      begin
        first_en_r[mviu_pkg::BIT_GLOBAL_EN] <= 1'b0;
      end
      else if (core_in.return_from_irq)
      begin
        first_en_r[mviu_pkg::BIT_GLOBAL_EN] <= 1'b1;
      end
    end
  end

  // Second register enables and configuration.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      second_en_r <= mviu_pkg::RST_CTRL_SECOND[2:0];
      config_r    <= mviu_pkg::RST_CONFIG;
    end
    else
    begin
      if (wr_en && hit_second)
      begin
        second_en_r <= pwdata[2:0];
      end
      if (wr_en && hit_config)
      begin
        config_r <= pwdata[1:0];
      end
    end
  end

  // Pin history for edge detection.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin0_d_r  <= 1'b0;
      pin1_d_r  <= 1'b0;
      hist_ok_r <= 1'b0;
    end
    else
    begin
      pin0_d_r  <= ext_irq_pin_zero;
      pin1_d_r  <= ext_irq_pin_one;
      hist_ok_r <= 1'b1;
    end
  end

  // Request sampled on each phase-two strobe; dropped at acknowledge or mask.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_r <= '0;
    end
    else if (core_in.irq_ack && req_r.valid)
    begin
      req_r <= '0;
    end
    else if (core_in.phase_two_pulse)
    begin
      req_r.valid  <= (|(pending_r & enabled)) && !core_in.stack_full;
      req_r.source <= pick_src(pending_r & enabled);
      req_r.vector <= src_vec(pick_src(pending_r & enabled));
    end
    else if (!first_en_r[mviu_pkg::BIT_GLOBAL_EN] || core_in.stack_full)
    begin
      req_r.valid <= 1'b0;
    end
  end

  // The source and vector are offered; the core saves the program counter alone.
  assign irq_req = req_r;

  // Any flagged source with its own enable wakes the core.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_up <= 1'b0;
    end
    else
    begin
      wake_up <= |(pending_r & {second_en_r[2:0], first_en_r[3:1]} & 6'h3F);
    end
  end

  // Read data, reserved bits zero.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      prdata <= 32'h0000_0000;
      if (hit_first)
      begin
        prdata[7:0] <= {1'b0, pending_r[2:0], first_en_r};
      end
      else if (hit_second)
      begin
        prdata[7:0] <= {1'b0, pending_r[5], pending_r[4], pending_r[3], 1'b0,
                        second_en_r[2:0]};
      end
      else if (hit_config)
      begin
        prdata[1:0] <= config_r;
      end
    end
  end

endmodule
`default_nettype wire
